// [pkg/dec_regs.svh]
/*
 * Offsets, field positions, reset values and timing counts of the data
 * nonvolatile-memory control block.
 * Assumes a 250 MHz system clock.
 */
`ifndef DEC_REGS_SVH
`define DEC_REGS_SVH

// ----------------------------------------
// Register selects on the register port
// ----------------------------------------
`define DEC_SEL_ADDR_LOW 2'h0
`define DEC_SEL_ADDR_HIGH 2'h1
`define DEC_SEL_DATA 2'h2
`define DEC_SEL_CTL 2'h3

// ----------------------------------------
// Control register fields and reset
// ----------------------------------------
`define DEC_B_TSEL 7
`define DEC_B_WEN 6
`define DEC_B_WGO 5
`define DEC_B_MODE 4
`define DEC_B_PEN 3
`define DEC_B_PGO 2
`define DEC_B_REN 1
`define DEC_B_RGO 0
`define DEC_CTL_RESET 8'h00
`define DEC_BYTE_RESET 8'h00
`define DEC_HIGH_RESET 2'h0

// ----------------------------------------
// Cycle durations
// ----------------------------------------
`define DEC_CLK_NS 4
`define DEC_WIPE0_NS 3200000
`define DEC_PROG0_NS 2200000
`define DEC_WIPE1_NS 3700000
`define DEC_PROG1_NS 3000000
`define DEC_WIPE0_CYC (`DEC_WIPE0_NS / `DEC_CLK_NS)
`define DEC_PROG0_CYC (`DEC_PROG0_NS / `DEC_CLK_NS)
`define DEC_WIPE1_CYC (`DEC_WIPE1_NS / `DEC_CLK_NS)
`define DEC_PROG1_CYC (`DEC_PROG1_NS / `DEC_CLK_NS)

`endif

// [pkg/dec_pkg.sv]
/*
 * Types of the data nonvolatile-memory control block.
 * Assumes nothing of its surroundings.
 */
package dec_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_READ_ISSUE = 3'h1,
		ST_READ_TAKE = 3'h2,
		ST_WIPE = 3'h3,
		ST_PROG = 3'h4
	} dec_state_type;
endpackage : dec_pkg

// [pkg/dec_tmr_if.sv]
/*
 * Link between the control logic and its cycle timer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface dec_tmr_if;
	logic start;
	logic [31:0] cycles;
	logic done;
	logic busy;
	modport ctl (output start, output cycles, input done, input busy);
	modport tmr (input start, input cycles, output done, output busy);
endinterface : dec_tmr_if
`default_nettype wire

// [core/dec_timer.sv]
/*
 * Cycle timer for wipe and program cycles.
 * Assumes start is a one-cycle pulse given only while not busy.
 */
`timescale 1ns/1ns
`default_nettype none
module dec_timer import dec_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control side
	dec_tmr_if.tmr tmr
);
	logic [31:0] count;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= 32'h0;
			tmr.busy <= 1'b0;
			tmr.done <= 1'b0;
		end else begin
			tmr.done <= 1'b0;
			if (tmr.start) begin
				count <= tmr.cycles - 32'h1;
				tmr.busy <= 1'b1;
			end else if (tmr.busy) begin
				if (count == 32'h0) begin
					tmr.busy <= 1'b0;
					tmr.done <= 1'b1;
				end else begin
					count <= count - 32'h1;
				end
			end
		end
	end
endmodule : dec_timer
`default_nettype wire

// [core/dec_control.sv]
/*
 * Control logic of a 1K x 8 data nonvolatile memory: address, data and
 * control registers, page buffer, read/program/wipe sequencing.
 * Assumes the array answers a read one cycle after arrayRead and applies
 * a commit (masked page write, zeros on wipe) on its own.
 */
`timescale 1ns/1ns
`default_nettype none
`include "dec_regs.svh"
module dec_control import dec_pkg::*; #(
	parameter int unsigned WIPE_CYC0 = `DEC_WIPE0_CYC,
	parameter int unsigned PROG_CYC0 = `DEC_PROG0_CYC,
	parameter int unsigned WIPE_CYC1 = `DEC_WIPE1_CYC,
	parameter int unsigned PROG_CYC1 = `DEC_PROG1_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire logic regWrEn,
	input wire logic [1:0] regSel,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	// Array side
	output logic [9:0] arrayAddr,
	output logic arrayRead,
	input wire logic [7:0] arrayRdData,
	output logic arrayCommit,
	output logic arrayErase,
	output logic [15:0] arrayMask,
	output logic [127:0] arrayData,
	// Events
	output logic completeEvent
);
	logic [7:0] ctl;
	logic [7:0] next_ctl;
	logic [7:0] addrLow;
	logic [1:0] addrHigh;
	logic [7:0] dataReg;
	logic [7:0] pageBuf [16];
	logic [15:0] bufTag;
	logic [127:0] bufFlat;
	dec_state_type state;
	dec_state_type next_state;
	dec_tmr_if tmr ();

	dec_timer uTimer (
		.clk(clk),
		.rst_b(rst_b),
		.tmr(tmr.tmr)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire ctlWr = regWrEn && (regSel == `DEC_SEL_CTL);
	wire dataWr = regWrEn && (regSel == `DEC_SEL_DATA);
	wire idle = (state == ST_IDLE);
	wire pageMode = ctl[`DEC_B_MODE];
	wire slowTime = ctl[`DEC_B_TSEL];
	// Enables are tested in their stored form, so a write raising both
	// enable and start together starts nothing
	wire goWipe = ctlWr && regWrData[`DEC_B_WGO] && ctl[`DEC_B_WEN] && idle;
	wire goProg = ctlWr && regWrData[`DEC_B_PGO] && ctl[`DEC_B_PEN] && idle;
	wire goRead = ctlWr && regWrData[`DEC_B_RGO] && ctl[`DEC_B_REN] && idle;
	wire finish = tmr.done && (state == ST_WIPE || state == ST_PROG);
	wire wiping = (state == ST_WIPE);
	wire opOk = wiping ? ctl[`DEC_B_WEN] : ctl[`DEC_B_PEN];
	wire [3:0] nib = addrLow[3:0];
	wire [3:0] nibNext = (nib == 4'hf) ? nib : nib + 4'h1;
	wire stepAddr = pageMode && ((dataWr && idle) || state == ST_READ_TAKE);
	wire wipeFall = ctl[`DEC_B_WEN] && !next_ctl[`DEC_B_WEN];
	wire [15:0] byteMask = 16'h0001 << nib;
	wire [7:0] rdMux = (regSel == `DEC_SEL_ADDR_LOW) ? addrLow :
		(regSel == `DEC_SEL_ADDR_HIGH) ? {6'h00, addrHigh} :
		(regSel == `DEC_SEL_DATA) ? dataReg : ctl;

	assign tmr.start = goWipe || goProg;
	assign tmr.cycles = goWipe ? (slowTime ? WIPE_CYC1 : WIPE_CYC0)
		: (slowTime ? PROG_CYC1 : PROG_CYC0);
	assign arrayAddr = {addrHigh, addrLow};

	always_comb begin
		for (int i = 0; i < 16; i++) begin
			bufFlat[i*8 +: 8] = pageBuf[i];
		end
	end

	// ----------------------------------------
	// Control register next value
	// ----------------------------------------
	// Start bits are owned by hardware once set: software can raise
	// them through the gates above but cannot drop a running cycle
	always_comb begin
		next_ctl = ctl;
		if (ctlWr) begin
			next_ctl = regWrData;
			next_ctl[`DEC_B_WGO] = ctl[`DEC_B_WGO] || goWipe;
			next_ctl[`DEC_B_PGO] = ctl[`DEC_B_PGO] || goProg;
			next_ctl[`DEC_B_RGO] = ctl[`DEC_B_RGO] || goRead;
		end
		if (finish && wiping) begin
			next_ctl[`DEC_B_WGO] = 1'b0;
			next_ctl[`DEC_B_WEN] = 1'b0;
		end
		if (finish && !wiping) begin
			next_ctl[`DEC_B_PGO] = 1'b0;
		end
		if (state == ST_READ_TAKE) begin
			next_ctl[`DEC_B_RGO] = 1'b0;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (goWipe) begin
					next_state = ST_WIPE;
				end else if (goProg) begin
					next_state = ST_PROG;
				end else if (goRead) begin
					next_state = ST_READ_ISSUE;
				end
			end
			ST_READ_ISSUE: next_state = ST_READ_TAKE;
			ST_READ_TAKE: next_state = ST_IDLE;
			ST_WIPE, ST_PROG: begin
				if (tmr.done) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			ctl <= `DEC_CTL_RESET;
		end else begin
			state <= next_state;
			ctl <= next_ctl;
		end
	end

	// ----------------------------------------
	// Address and data registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addrLow <= `DEC_BYTE_RESET;
			addrHigh <= `DEC_HIGH_RESET;
			dataReg <= `DEC_BYTE_RESET;
		end else begin
			if (regWrEn && regSel == `DEC_SEL_ADDR_LOW) begin
				addrLow <= regWrData;
			end else if (stepAddr) begin
				addrLow <= {addrLow[7:4], nibNext};
			end
			if (regWrEn && regSel == `DEC_SEL_ADDR_HIGH) begin
				addrHigh <= regWrData[1:0];
			end
			if (dataWr) begin
				dataReg <= regWrData;
			end else if (state == ST_READ_TAKE) begin
				dataReg <= arrayRdData;
			end
		end
	end

	// ----------------------------------------
	// Page buffer
	// ----------------------------------------
	// Data writes in page mode tag the byte; the tags also pick the bytes
	// that a page wipe clears
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bufTag <= 16'h0000;
			for (int i = 0; i < 16; i++) begin
				pageBuf[i] <= 8'h00;
			end
		end else if (wipeFall) begin
			bufTag <= 16'h0000;
			for (int i = 0; i < 16; i++) begin
				pageBuf[i] <= 8'h00;
			end
		end else if (dataWr && idle && pageMode) begin
			bufTag <= bufTag | byteMask;
			pageBuf[nib] <= regWrData;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdData <= 8'h00;
			arrayRead <= 1'b0;
			arrayCommit <= 1'b0;
			arrayErase <= 1'b0;
			arrayMask <= 16'h0000;
			arrayData <= 128'h0;
			completeEvent <= 1'b0;
		end else begin
			regRdData <= rdMux;
			arrayRead <= goRead;
			arrayCommit <= finish && opOk;
			arrayErase <= finish && wiping;
			completeEvent <= finish;
			if (finish) begin
				arrayMask <= pageMode ? bufTag : byteMask;
				arrayData <= wiping ? 128'h0
					: (pageMode ? bufFlat : {16{dataReg}});
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_readGo;
		goRead;
	endsequence
	sequence s_readRun;
		##1 (arrayRead && ctl[`DEC_B_RGO]) ##2 !ctl[`DEC_B_RGO];
	endsequence
	sequence s_wipeEnd;
		finish && wiping;
	endsequence

	a_read_gate_off: assert property (ctlWr && regWrData[`DEC_B_RGO] && !ctl[`DEC_B_REN] && !ctl[`DEC_B_RGO] |=> !ctl[`DEC_B_RGO]) else $error("read start took without enable");
	a_wipe_gate_off: assert property (ctlWr && regWrData[`DEC_B_WGO] && !ctl[`DEC_B_WEN] && !ctl[`DEC_B_WGO] |=> !ctl[`DEC_B_WGO] && state != ST_WIPE) else $error("wipe start took without enable");
	a_prog_gate_off: assert property (ctlWr && regWrData[`DEC_B_PGO] && !ctl[`DEC_B_PEN] && !ctl[`DEC_B_PGO] |=> !ctl[`DEC_B_PGO] && state != ST_PROG) else $error("program start took without enable");
	a_read_cycle_run: assert property (s_readGo |-> s_readRun) else $error("read cycle did not run and clear");
	a_wipe_end_clear: assert property (s_wipeEnd |=> !ctl[`DEC_B_WGO] && !ctl[`DEC_B_WEN] && completeEvent && arrayErase) else $error("wipe end did not clear bits");
	a_prog_hold_bit: assert property (goProg |=> ctl[`DEC_B_PGO] [*8]) else $error("program start bit dropped early");
	a_prog_block_off: assert property (finish && !wiping && !ctl[`DEC_B_PEN] |=> !arrayCommit && completeEvent) else $error("program committed while disabled");
	a_page_addr_sat: assert property (dataWr && idle && pageMode && nib == 4'hf |=> addrLow[3:0] == 4'hf && $stable(addrLow[7:4])) else $error("page address rolled over");
	a_buf_clear_fall: assert property (wipeFall |=> bufTag == 16'h0000) else $error("page buffer kept after enable fall");
endmodule : dec_control
`default_nettype wire

// [dv/tb_top.sv]
/*
 * Self-checking bench of the data nonvolatile-memory control block.
 * Assumes tb_top as top, with dec_control run on shortened cycle counts.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top import dec_pkg::*;;
	localparam int W0 = 20;
	localparam int P0 = 12;
	localparam int W1 = 24;
	localparam int P1 = 16;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic regWrEn = 1'b0;
	logic [1:0] regSel = 2'h0;
	logic [7:0] regWrData = 8'h00;
	logic [7:0] arrayRdData = 8'h00;
	logic [7:0] regRdData;
	logic [9:0] arrayAddr;
	logic arrayRead;
	logic arrayCommit;
	logic arrayErase;
	logic [15:0] arrayMask;
	logic [127:0] arrayData;
	logic completeEvent;
	int fails = 0;
	int total_checks = 0;

	always #2 clk = ~clk;

	dec_control #(.WIPE_CYC0(W0), .PROG_CYC0(P0), .WIPE_CYC1(W1),
		.PROG_CYC1(P1)) dec_control_i (.clk(clk), .rst_b(rst_b),
		.regWrEn(regWrEn), .regSel(regSel), .regWrData(regWrData),
		.regRdData(regRdData), .arrayAddr(arrayAddr),
		.arrayRead(arrayRead), .arrayRdData(arrayRdData),
		.arrayCommit(arrayCommit), .arrayErase(arrayErase),
		.arrayMask(arrayMask), .arrayData(arrayData),
		.completeEvent(completeEvent));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task test_done;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	task chk(input string name, input logic [127:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %s exp %h got %h", name, exp, got);
		end
	endtask : chk

	task wr(input logic [1:0] sel, input logic [7:0] d);
		@(posedge clk);
		regWrEn <= 1'b1;
		regSel <= sel;
		regWrData <= d;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask : wr

	// Three edges: select, then a settled registered read
	task rd(input logic [1:0] sel, input logic [7:0] exp, input string nm);
		@(posedge clk);
		regSel <= sel;
		@(posedge clk);
		@(posedge clk);
		#1 chk(nm, exp, regRdData);
	endtask : rd

	// Enable, then start, then a bounded wait for the cycle end
	task cyc(input logic [7:0] en, go, input int n, input logic er,
		input logic [15:0] mask, input logic [127:0] data,
		input logic drop);
		int c;
		wr(2'h3, en);
		wr(2'h3, en | go);
		c = 0;
		// Enable cleared two edges after the start write
		if (drop) begin
			wr(2'h3, en & 8'hf7);
			c = 2;
		end
		while (c < 200 && completeEvent !== 1'b1) begin
			@(posedge clk);
			c++;
			#1;
		end
		chk("cycle length", n + 1, c);
		chk("commit", !drop, arrayCommit);
		chk("erase", er, arrayErase);
		chk("mask", mask, arrayMask);
		chk("page data", data, arrayData);
		if (c >= 200) begin
			test_done();
		end
	endtask : cyc

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int s;
		int c;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] b;
		void'($urandom(32'h101b8bfb));
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		for (s = 0; s < 4; s++) begin
			rd(s[1:0], 8'h00, "reset value");
		end
		// Each start bit alone, with no enable stored, stays low
		for (s = 0; s < 3; s++) begin
			wr(2'h3, (s == 0) ? 8'h01 : ((s == 1) ? 8'h04 : 8'h20));
			rd(2'h3, 8'h00, "lone start");
		end
		d = $urandom;
		a = $urandom;
		arrayRdData <= d;
		wr(2'h0, a);
		wr(2'h1, 8'hfd);
		rd(2'h1, 8'h01, "addr high");
		wr(2'h3, 8'h02);
		wr(2'h3, 8'h03);
		c = 0;
		// Pulse is launched at the start edge; let it settle first
		#1;
		while (c < 8 && arrayRead !== 1'b1) begin
			@(posedge clk);
			c++;
			#1;
		end
		chk("read pulse", 1'b1, arrayRead);
		chk("read addr", {2'h1, a}, arrayAddr);
		if (c >= 8) begin
			test_done();
		end
		rd(2'h3, 8'h02, "read done");
		rd(2'h2, d, "read data");
		// Read refused once its enable is cleared
		wr(2'h3, 8'h00);
		arrayRdData <= ~d;
		wr(2'h3, 8'h01);
		rd(2'h3, 8'h00, "blocked start");
		rd(2'h2, d, "blocked data");
		for (s = 0; s < 2; s++) begin
			b = s ? 8'h80 : 8'h00;
			a = $urandom;
			d = $urandom;
			wr(2'h0, {a[7:4], 4'he});
			wr(2'h3, b | 8'h10);
			repeat (3) wr(2'h2, d);
			rd(2'h0, {a[7:4], 4'hf}, "nibble stop");
			chk("page addr", {2'h1, a[7:4], 4'hf}, arrayAddr);
			cyc(b | 8'h50, 8'h20, s ? W1 : W0, 1'b1, 16'hc000, 0,
				1'b0);
			rd(2'h3, b | 8'h10, "wipe end");
			// Wipe-enable fall emptied the buffer
			cyc(b | 8'h18, 8'h04, s ? P1 : P0, 1'b0, 16'h0000, 0,
				1'b0);
			// Byte mode first, so the data write does not step the address
			wr(2'h3, b | 8'h08);
			wr(2'h0, a);
			wr(2'h2, d);
			cyc(b | 8'h08, 8'h04, s ? P1 : P0, 1'b0, 16'h1 << a[3:0],
				{16{d}}, 1'b0);
			rd(2'h3, b | 8'h08, "program end");
		end
		// Program enable dropped mid-cycle: event without commit
		cyc(8'h08, 8'h04, P0, 1'b0, 16'h1 << a[3:0], {16{d}},
			1'b1);
		rd(2'h3, 8'h00, "dropped end");
		test_done();
	end
endmodule : tb_top
`default_nettype wire
